// >>> inc/lsp_cfg.svh
// Constants for the lamp switch serial port: field layout, register addresses and codes.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef LSP_CFG_SVH
`define LSP_CFG_SVH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define LSP_WORD_BITS     16
`define LSP_ADDR_MSB      14
`define LSP_ADDR_LSB      10
`define LSP_DATA_MSB      9
`define LSP_REG_COUNT     32

// ----------------------------------------------------------------------
// Sense selector codes (data bits [2:0] of the sense register)
// ----------------------------------------------------------------------
`define LSP_SENSE_ADDR    5'h01
`define LSP_SENSE_OFF     3'h0
`define LSP_SENSE_TEMP    3'h5

// ----------------------------------------------------------------------
// Register holding direct-control flags and pwm clock select
// ----------------------------------------------------------------------
`define LSP_CTRL_ADDR     5'h02
`define LSP_CTRL_PWM_BIT  4
`define LSP_CTRL_EXT_BIT  5

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define LSP_REG_RESET     10'h000

`endif

// >>> inc/lsp_pkg.sv
// Types shared by the lamp switch serial port design.
// Assumes lsp_cfg.svh for numeric constants.
package lsp_pkg;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef logic [15:0] lsp_word_t;
  typedef logic [4:0]  lsp_addr_t;
  typedef logic [9:0]  lsp_data_t;

  typedef enum logic [1:0] {
    LSP_SLEEP,
    LSP_NORMAL,
    LSP_FAILSAFE,
    LSP_FAULT
  } lsp_mode_e;

  typedef enum logic [1:0] {
    LSP_SENSE_HIZ,
    LSP_SENSE_CURRENT,
    LSP_SENSE_BOARD_TEMP
  } lsp_sense_e;

endpackage : lsp_pkg

// >>> rtl/lsp_regfile.sv
// Small register memory written at frame end, read data registered.
// Assumes a single clock domain; clear empties every word.
`timescale 1ns/10ps
module lsp_regfile #(
  parameter int DEPTH = 32,
  parameter int WIDTH = 10
) (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     clear,
  input  wire logic                     wr_en,
  input  wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input  wire logic [WIDTH-1:0]         wr_data,
  input  wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic      [WIDTH-1:0]         rd_data
);

  logic [WIDTH-1:0] mem_q [DEPTH];

  // ----------------------------------------------------------------------
  // Storage and registered read
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= '0;
      end
      rd_data <= '0;
    end else begin
      if (clear) begin
        for (int i = 0; i < DEPTH; i++) begin
          mem_q[i] <= '0;
        end
      end else if (wr_en) begin
        mem_q[wr_addr] <= wr_data;
      end
      rd_data <= mem_q[rd_addr];
    end
  end

endmodule : lsp_regfile

// >>> rtl/lsp_serial_port.sv
// Serial control port and control-pin logic of a quad high side lamp switch.
// Assumes all pins are asynchronous to clk; all but vdd_ok and channel_faults are synchronised here.
//
// Notes on behaviour
// [R1] Serial input is sampled on each falling serial clock edge during select.
// [R2] Host sends exactly sixteen bits per command, most significant first.
// [R3] Serial output changes on each rising serial clock edge.
// [R4] Select rising edge writes the received word to its addressed register.
// [R5] Select falling edge loads current status into the output shifter.
// [R6] Serial output driven only while select is low, otherwise released.
// [R7] Clock and input activity are ignored while select is high.
// [R8] Host keeps serial clock low while changing select.
// [R9] A five-bit address field selects the target register.
// [R10] Host keeps serial clock under its maximum rate.
// [R11] Host holds reset low at least its minimum time.
// [R12] Host waits the enable time after reset before selecting.
// [R13] Host keeps select high a minimum time between frames.
// [R14] Reset low clears configuration and faults and forces sleep; here sleep only if wake pin and direct inputs are also low, and faults are not cleared.
// [R15] Reset rising starts watchdog; reset high also wakes.
// [R16] Each direct input wakes and directly drives its output; here in fault mode a faulted channel stays off.
// [R17] Direct input zero supplies the pwm clock when external clock used.
// [R18] Wake pin high wakes the device.
// [R19] Any fault pulls the open-drain fault flag low; details over serial; here only while awake.
// [R20] Loss of logic supply enters fail-safe mode; here only while awake and with no channel fault, since fault mode wins.
// [R21] Sense output reports a channel current, board temperature, or is off.
// [R22] Status words report outputs, configuration and key input pins.
// [R23] With no wake source asleep: outputs off, configuration read as zero.
// [R24] Full duplex: reply shifts out while command shifts in, msb first.
`timescale 1ns/10ps
`include "lsp_cfg.svh"
module lsp_serial_port #(
  parameter int CHANNELS = 4
) (
  input  wire logic                clk,
  input  wire logic                rst,
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                si,
  input  wire logic                reset_n_pin,
  input  wire logic                wake_pin,
  input  wire logic [CHANNELS-1:0] direct_inputs,
  input  wire logic                vdd_ok,
  input  wire logic [CHANNELS-1:0] channel_faults,
  output logic                     so_o,
  output logic                     so_oe,
  output logic                     fault_flag_pin_o,
  output logic                     fault_flag_pin_oe,
  output logic [CHANNELS-1:0]      high_side_outputs,
  output logic                     pwm_clk,
  output logic                     watchdog_start,
  output lsp_pkg::lsp_mode_e       mode,
  output lsp_pkg::lsp_sense_e      sense_output_mode,
  output logic [1:0]               sense_channel
);
  import lsp_pkg::*;

  localparam int NSYNC = 5 + CHANNELS;

  // Block state apart from the register read flops
  typedef struct packed {
    logic [NSYNC-1:0]   s1;
    logic [NSYNC-1:0]   s2;
    logic               sclk_prev;
    logic               cs_prev;
    logic               rst_prev;
    lsp_word_t          rx;
    lsp_word_t          tx;
    logic [4:0]         bits;
    logic               so;
    logic               so_oe;
    logic               ff_oe;
    logic [CHANNELS-1:0] hs;
    logic               pclk;
    logic               wd;
    lsp_mode_e          mode;
    lsp_sense_e         sense;
    logic [1:0]         sch;
    logic               wr;
    lsp_addr_t          waddr;
    lsp_data_t          wdata;
  } lsp_state_s;

  lsp_state_s st_q;
  lsp_state_s st_d;

  logic      cfg_clear;
  lsp_addr_t rd_addr;
  lsp_data_t rd_data;
  lsp_data_t ctrl_q;
  lsp_data_t sense_q;

  // Decode sense selection from a register word
  function automatic lsp_sense_e lsp_sense_decode(input lsp_data_t d);
    if (d[2:0] == `LSP_SENSE_OFF) begin
      return LSP_SENSE_HIZ;
    end else if (d[2:0] == `LSP_SENSE_TEMP) begin
      return LSP_SENSE_BOARD_TEMP;
    end
    return LSP_SENSE_CURRENT;
  endfunction : lsp_sense_decode

  // ----------------------------------------------------------------------
  // Synchronised pin views (second stage only)
  // ----------------------------------------------------------------------
  logic                sclk_s;
  logic                cs_s;
  logic                si_s;
  logic                rstp_s;
  logic                wake_s;
  logic [CHANNELS-1:0] in_s;
  logic                wake_any;

  assign sclk_s   = st_q.s2[0];
  assign cs_s     = st_q.s2[1];
  assign si_s     = st_q.s2[2];
  assign rstp_s   = st_q.s2[3];
  assign wake_s   = st_q.s2[4];
  assign in_s     = st_q.s2[NSYNC-1:5];
  assign wake_any = rstp_s | wake_s | (|in_s); // R15 R16 R18

  // Configuration cleared while reset pin low or asleep
  assign cfg_clear = ~rstp_s; // R14

  // ----------------------------------------------------------------------
  // Register memory: written at frame end, read for config
  // ----------------------------------------------------------------------
  lsp_regfile #(
    .DEPTH(`LSP_REG_COUNT),
    .WIDTH(10)
  ) u_regs (
    .clk     (clk),
    .rst     (rst),
    .clear   (cfg_clear),
    .wr_en   (st_q.wr),
    .wr_addr (st_q.waddr),
    .wr_data (st_q.wdata),
    .rd_addr (rd_addr),
    .rd_data (rd_data)
  );

  // Alternate reads between control and sense words
  logic rd_sel_q;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_sel_q <= 1'b0;
      ctrl_q   <= `LSP_REG_RESET;
      sense_q  <= `LSP_REG_RESET;
    end else begin
      rd_sel_q <= ~rd_sel_q;
      // Data for rd_sel_q arrives one cycle later
      if (rd_sel_q) begin
        ctrl_q <= rd_data;
      end else begin
        sense_q <= rd_data;
      end
    end
  end
  assign rd_addr = rd_sel_q ? `LSP_SENSE_ADDR : `LSP_CTRL_ADDR;

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------
  always_comb begin
    logic sclk_fall;
    logic sclk_rise;
    logic cs_fall;
    logic cs_rise;
    logic awake;
    logic any_fault;
    lsp_data_t ctrl_eff;
    lsp_data_t sense_eff;
    sclk_fall = 1'b0;
    sclk_rise = 1'b0;
    cs_fall   = 1'b0;
    cs_rise   = 1'b0;
    awake     = 1'b0;
    any_fault = 1'b0;
    ctrl_eff  = '0;
    sense_eff = '0;
    st_d = st_q;

    // Two-stage synchroniser for every pin except vdd_ok and channel_faults
    st_d.s1 = {direct_inputs, wake_pin, reset_n_pin, si, cs_n, sclk};
    st_d.s2 = st_q.s1;
    st_d.sclk_prev = sclk_s;
    st_d.cs_prev   = cs_s;
    st_d.rst_prev  = rstp_s;

    sclk_fall = st_q.sclk_prev & ~sclk_s & ~cs_s; // R7
    sclk_rise = ~st_q.sclk_prev & sclk_s & ~cs_s; // R7
    cs_fall   = st_q.cs_prev & ~cs_s;
    cs_rise   = ~st_q.cs_prev & cs_s;
    awake     = wake_any;
    any_fault = |channel_faults;

    // Sleep reads configuration as zero
    ctrl_eff  = awake ? ctrl_q : '0; // R23
    sense_eff = awake ? sense_q : '0; // R23
    st_d.wr   = 1'b0;

    // Frame start: load status and drive first bit
    if (cs_fall) begin
      st_d.tx   = {1'b0, any_fault, st_q.mode, in_s, st_q.hs,
                   ctrl_eff[3:0]}; // R5 R22
      st_d.bits = '0;
      st_d.so   = st_d.tx[15]; // R24
    end else if (sclk_fall) begin
      st_d.rx   = {st_q.rx[14:0], si_s}; // R1 R24
      st_d.bits = st_q.bits + 5'h01;
    end else if (sclk_rise && st_q.bits != 5'h00) begin
      st_d.tx = {st_q.tx[14:0], 1'b0};
      st_d.so = st_q.tx[14]; // R3
    end

    // Frame end: commit a full word to its address
    if (cs_rise && st_q.bits == 5'(`LSP_WORD_BITS) && rstp_s) begin
      st_d.wr    = 1'b1; // R4
      st_d.waddr = st_q.rx[`LSP_ADDR_MSB:`LSP_ADDR_LSB]; // R9
      st_d.wdata = st_q.rx[`LSP_DATA_MSB:0];
    end

    // Output driver enabled only inside a frame
    st_d.so_oe = ~cs_s & ~cs_rise; // R6

    // Watchdog start pulse on reset pin rising
    st_d.wd = rstp_s & ~st_q.rst_prev; // R15

    // Mode selection
    if (!awake || !rstp_s && !wake_s && !(|in_s)) begin
      st_d.mode = LSP_SLEEP; // R23
    end else if (any_fault) begin
      st_d.mode = LSP_FAULT;
    end else if (!vdd_ok) begin
      st_d.mode = LSP_FAILSAFE; // R20
    end else begin
      st_d.mode = LSP_NORMAL;
    end

    // Output drive per mode
    case (st_d.mode)
      LSP_SLEEP:    st_d.hs = '0; // R23
      LSP_FAILSAFE: st_d.hs = in_s; // R16
      LSP_FAULT:    st_d.hs = in_s & ~channel_faults;
      LSP_NORMAL:   st_d.hs = ctrl_eff[`LSP_CTRL_PWM_BIT] ? in_s :
                              (in_s | ctrl_eff[3:0]); // R16
      default:      st_d.hs = '0;
    endcase

    // External pwm clock from direct input zero
    st_d.pclk = ctrl_eff[`LSP_CTRL_EXT_BIT] & in_s[0]; // R17

    // Fault flag pulled low on any fault while awake
    st_d.ff_oe = any_fault & awake; // R19

    // Sense selection
    st_d.sense = lsp_sense_decode(sense_eff); // R21
    st_d.sch   = sense_eff[4:3];
  end

  // ----------------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q         <= '0;
      // Select idles high so no false frame edge follows reset
      st_q.s1[1]   <= 1'b1;
      st_q.s2[1]   <= 1'b1;
      st_q.cs_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs straight from flops, except fault flag level tied low
  // ----------------------------------------------------------------------
  assign so_o              = st_q.so;
  assign so_oe             = st_q.so_oe;
  assign fault_flag_pin_o  = 1'b0;
  assign fault_flag_pin_oe = st_q.ff_oe;
  assign high_side_outputs = st_q.hs;
  assign pwm_clk           = st_q.pclk;
  assign watchdog_start    = st_q.wd;
  assign mode              = st_q.mode;
  assign sense_output_mode = st_q.sense;
  assign sense_channel     = st_q.sch;

endmodule : lsp_serial_port

// >>> test/lsp_serial_port_sva.sv
// Checker for the lamp switch serial port pins and mode.
// Assumes it is bound to lsp_serial_port and sees only its ports.
`timescale 1ns/10ps
module lsp_serial_port_sva #(
  parameter int CHANNELS = 4
) (
  input wire logic                clk,
  input wire logic                rst,
  input wire logic                sclk,
  input wire logic                cs_n,
  input wire logic                reset_n_pin,
  input wire logic                wake_pin,
  input wire logic [CHANNELS-1:0] direct_inputs,
  input wire logic                vdd_ok,
  input wire logic [CHANNELS-1:0] channel_faults,
  input wire logic                so_o,
  input wire logic                so_oe,
  input wire logic                fault_flag_pin_o,
  input wire logic                fault_flag_pin_oe,
  input wire logic [CHANNELS-1:0] high_side_outputs,
  input wire logic                watchdog_start,
  input lsp_pkg::lsp_mode_e       mode
);
  import lsp_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  so_released_a: assert property (cs_n [*8] |-> !so_oe)
    else $error("serial out driven while deselected");
  so_enabled_a: assert property ($fell(cs_n) |-> ##[2:6] so_oe)
    else $error("serial out not enabled after select");
  so_hold_a: assert property ((so_oe && !sclk) [*6] |-> $stable(so_o))
    else $error("serial out moved without clock rise");
  flag_level_a: assert property (fault_flag_pin_o == 1'b0)
    else $error("fault flag driven high");
  flag_pull_a: assert property ((channel_faults != 0 && (reset_n_pin || wake_pin)) [*6]
    |-> fault_flag_pin_oe)
    else $error("fault flag not pulled on fault");
  sleep_off_a: assert property ((!reset_n_pin && !wake_pin && direct_inputs == 0) [*6]
    |-> mode == LSP_SLEEP && high_side_outputs == 0)
    else $error("not asleep without wake source");
  fail_safe_a: assert property ((!vdd_ok && (reset_n_pin || wake_pin) && channel_faults == 0) [*6]
    |-> mode == LSP_FAILSAFE)
    else $error("no fail-safe on supply loss");
  wdog_start_a: assert property ($rose(reset_n_pin) |-> ##[2:6] watchdog_start)
    else $error("watchdog not started");
  wdog_pulse_a: assert property (watchdog_start |=> !watchdog_start)
    else $error("watchdog start longer than a cycle");
  // Main scenarios seen
  cover property ($fell(cs_n));
  cover property (watchdog_start);
  cover property (mode == LSP_FAILSAFE);
  cover property (fault_flag_pin_oe);
endmodule : lsp_serial_port_sva

bind lsp_serial_port lsp_serial_port_sva #(.CHANNELS(CHANNELS)) i_sva (.clk, .rst,
  .sclk, .cs_n, .reset_n_pin, .wake_pin, .direct_inputs, .vdd_ok, .channel_faults,
  .so_o, .so_oe, .fault_flag_pin_o, .fault_flag_pin_oe, .high_side_outputs,
  .watchdog_start, .mode);

// >>> test/lsp_host_model.sv
// Host model: serial master sending command frames, collecting replies.
// Assumes so_line is the resolved serial output wire.
`timescale 1ns/10ps
module lsp_host_model (
  output logic      sclk,
  output logic      cs_n,
  output logic      si,
  input  wire logic so_line
);
  import lsp_pkg::*;
  // Idle: clock low, deselected, data at pull-down level
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
  end
  // Frame of n bits msb first; 80 ns halves stay below 8 MHz
  task automatic frame(input lsp_word_t w, input int n, output lsp_word_t r);
    r = '0;
    cs_n = 1'b0;
    #500;
    for (int i = 15; i > 15 - n; i--) begin
      #40 si = w[i]; // Data moves mid low phase, clear of the falling edge
      #40 sclk = 1'b1;
      #80 r = {r[14:0], so_line};
      sclk = 1'b0;
    end
    #80 cs_n = 1'b1;
    si = 1'b0;
    #1000;
  endtask : frame
  // Clock and data activity while deselected
  task automatic noise(input int n);
    repeat (n) begin
      si = ~si;
      #80 sclk = 1'b1;
      #80 sclk = 1'b0;
    end
    si = 1'b0;
  endtask : noise
endmodule : lsp_host_model

// >>> test/lsp_serial_port_tb.sv
// Testbench for the lamp switch serial port: table of writes, then edge cases.
// Assumes lsp_host_model as serial master and the bound checker.
`timescale 1ns/10ps
`include "lsp_cfg.svh"
module lsp_serial_port_tb;
  import lsp_pkg::*;
  typedef struct {
    logic [9:0] ctl, sns;
    logic [3:0] din, hs;
    logic       pwm;
    logic [1:0] sm, ch;
  } lsp_row_s;
  logic       clk = 1'b0, rst = 1'b1, reset_n_pin = 1'b0, wake_pin = 1'b0, vdd_ok = 1'b1;
  logic [3:0] direct_inputs = 4'h0, channel_faults = 4'h0, high_side_outputs;
  logic       so_o, so_oe, fault_flag_pin_o, fault_flag_pin_oe, pwm_clk, watchdog_start;
  logic       so_inv = 1'b0;
  wire logic  sclk, cs_n, si, so_line;
  lsp_mode_e  mode;
  lsp_sense_e sense_output_mode;
  logic [1:0] sense_channel;
  lsp_word_t  rx;
  int         n_errors = 0, total_checks = 0;
  lsp_row_s   rows [5] = '{'{10'h005, 10'h000, 4'h0, 4'h5, 1'b0, 2'h0, 2'h0},
    '{10'h00a, 10'h005, 4'h0, 4'ha, 1'b0, 2'h2, 2'h0},
    '{10'h000, 10'h00a, 4'h6, 4'h6, 1'b0, 2'h1, 2'h1},
    '{10'h020, 10'h01b, 4'h1, 4'h1, 1'b1, 2'h1, 2'h3},
    '{10'h00f, 10'h011, 4'h0, 4'hf, 1'b0, 2'h1, 2'h2}};
  // Clock and released serial line showing the inverse of its last value
  always #5 clk = ~clk;
  always @(posedge clk) if (so_oe) so_inv <= ~so_o;
  assign so_line = so_oe ? so_o : so_inv;
  lsp_serial_port i_dut (.clk, .rst, .sclk, .cs_n, .si, .reset_n_pin, .wake_pin,
    .direct_inputs, .vdd_ok, .channel_faults, .so_o, .so_oe, .fault_flag_pin_o,
    .fault_flag_pin_oe, .high_side_outputs, .pwm_clk, .watchdog_start, .mode,
    .sense_output_mode, .sense_channel);
  lsp_host_model i_host (.sclk, .cs_n, .si, .so_line);
  // Compare helpers, verdict and step
  task automatic chk_v(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_v
  task automatic chk_m(input lsp_mode_e got, input lsp_mode_e exp);
    chk_v({14'h0, got}, {14'h0, exp});
  endtask : chk_m
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : tally_and_finish
  // Watchdog on the whole run
  initial begin
    #400000;
    n_errors++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    step(20);
    chk_v({so_oe, high_side_outputs}, 5'h00);
    rst = 1'b0;
    step(1000);
    chk_m(mode, LSP_SLEEP);
    reset_n_pin = 1'b1;
    #5000;
    $display("test reset done");
    foreach (rows[k]) begin
      direct_inputs = rows[k].din;
      i_host.frame({1'b0, `LSP_CTRL_ADDR, rows[k].ctl}, 16, rx);
      i_host.frame({1'b0, `LSP_SENSE_ADDR, rows[k].sns}, 16, rx);
      i_host.frame({1'b0, `LSP_CTRL_ADDR, rows[k].ctl}, 16, rx);
      chk_v(rx, {4'h1, rows[k].din, rows[k].hs, rows[k].ctl[3:0]});
      step(10);
      chk_v({high_side_outputs, pwm_clk}, {rows[k].hs, rows[k].pwm});
      chk_v({sense_output_mode, sense_channel}, {rows[k].sm, rows[k].ch});
    end
    direct_inputs = 4'h0;
    $display("test table done");
    i_host.noise(5);
    i_host.frame({1'b0, `LSP_CTRL_ADDR, 10'h003}, 16, rx);
    i_host.frame({1'b0, `LSP_CTRL_ADDR, 10'h00c}, 15, rx);
    i_host.frame({1'b0, `LSP_CTRL_ADDR, 10'h003}, 16, rx);
    chk_v(rx[3:0], 4'h3);
    $display("test framing done");
    channel_faults = 4'h2;
    step(10);
    chk_v(fault_flag_pin_oe, 1'b1);
    chk_m(mode, LSP_FAULT);
    i_host.frame({1'b0, `LSP_SENSE_ADDR, 10'h000}, 16, rx);
    chk_v(rx[15:12], 4'h7);
    channel_faults = 4'h0;
    vdd_ok = 1'b0;
    step(10);
    chk_m(mode, LSP_FAILSAFE);
    vdd_ok = 1'b1;
    $display("test faults done");
    reset_n_pin = 1'b0;
    step(1000);
    chk_m(mode, LSP_SLEEP);
    chk_v(high_side_outputs, 4'h0);
    wake_pin = 1'b1;
    step(10);
    chk_m(mode, LSP_NORMAL);
    wake_pin = 1'b0;
    reset_n_pin = 1'b1;
    #5000;
    i_host.frame({1'b0, `LSP_CTRL_ADDR, 10'h000}, 16, rx);
    chk_v(rx[3:0], 4'h0);
    $display("test sleep done");
    tally_and_finish();
  end
endmodule : lsp_serial_port_tb
